// >>> src/prot_stage_pkg.sv
// Shared types and constants for the programmable protection stages
package prot_stage_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_STAGES  = 8;
  localparam int NUM_SIGNALS = 48;
  localparam int SEL_W       = 6;
  localparam int VAL_W       = 24;
  localparam int CNT_W       = 16;
  localparam int DLY_W       = 16;
  localparam int NUM_GROUPS  = 4;
  localparam int FAULT_DEPTH = 8;
  localparam int STAMP_W     = 48;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint CLK_HZ         = 64'd50000000;
  localparam longint FORCE_TIMEOUT_S = 64'd300;
  localparam longint FORCE_CYCLES   = FORCE_TIMEOUT_S * CLK_HZ;
  localparam int     FORCE_CNT_W    = 34;
  localparam longint PRIO_10_MS     = 64'd10;
  localparam longint PRIO_20_MS     = 64'd20;
  localparam longint PRIO_100_MS    = 64'd100;
  localparam longint PRIO_10_CYC    = PRIO_10_MS * CLK_HZ / 64'd1000;
  localparam longint PRIO_20_CYC    = PRIO_20_MS * CLK_HZ / 64'd1000;
  localparam longint PRIO_100_CYC   = PRIO_100_MS * CLK_HZ / 64'd1000;
  localparam int     TICK_W         = 23;

  // ****************************************
  // Signal selector codes
  // ****************************************
  localparam logic [SEL_W-1:0] SIG_IL1   = 6'h00;
  localparam logic [SEL_W-1:0] SIG_VIRT_FIRST = 6'h25;
  localparam logic [SEL_W-1:0] SIG_VIRT_LAST  = 6'h29;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [1:0] {
    OVER_MODE, UNDER_MODE, DIFFERENCE_MODE, ABSOLUTE_DIFFERENCE_MODE
  } comparison_selector_t;

  typedef enum logic [1:0] {PRIO_10, PRIO_20, PRIO_100} priority_t;

  // ****************************************
  // Structs
  // ****************************************
  typedef struct packed {
    logic                 enable;
    logic [SEL_W-1:0]     coupling_a;
    logic [SEL_W-1:0]     coupling_b;
    comparison_selector_t comparison_selector;
    logic signed [VAL_W-1:0] pickup;
    logic [VAL_W-1:0]     hysteresis;
    logic signed [VAL_W-1:0] no_compare_floor;
    logic [DLY_W-1:0]     delay_ticks;
    priority_t            prio;
  } stage_cfg_t;

  typedef struct packed {
    logic [STAMP_W-1:0]      stamp;
    logic signed [VAL_W-1:0] value;
    logic [7:0]              elapsed_delay_ratio;
    logic [1:0]              active_settings_bank;
  } fault_rec_t;

  typedef struct packed {
    logic             start;
    logic             trip;
    logic [CNT_W-1:0] start_event_count;
    logic [CNT_W-1:0] trip_event_count;
  } stage_stat_t;

  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [7:0]       PCT_FULL  = 8'h64;

endpackage : prot_stage_pkg

// >>> src/prot_stage_unit.sv
// One programmable protection stage: compare, delay, counters, fault log
`timescale 1ns/1ns
module prot_stage_unit (
  input  wire logic                              ref_clk,
  input  wire logic                              arst_n,
  input  wire logic                              tick,
  input  prot_stage_pkg::stage_cfg_t             cfg,
  input  wire logic signed [prot_stage_pkg::VAL_W-1:0] val_a,
  input  wire logic signed [prot_stage_pkg::VAL_W-1:0] val_b,
  input  wire logic                              force_on,
  input  wire logic                              force_wr,
  input  wire logic                              force_start,
  input  wire logic                              force_trip,
  input  wire logic                              clear_counts,
  input  wire logic [1:0]                        bank,
  input  wire logic [prot_stage_pkg::STAMP_W-1:0] stamp,
  input  wire logic [2:0]                        log_idx,
  output prot_stage_pkg::stage_stat_t            stat,
  output prot_stage_pkg::fault_rec_t             log_out
);

  // ****************************************
  // Comparison
  // ****************************************
  // Two guard bits so pickup plus or minus the dead band cannot wrap
  localparam int CW = prot_stage_pkg::VAL_W + 2;
  logic signed [CW-1:0] op_a;
  logic signed [CW-1:0] op_b;
  logic signed [CW-1:0] sup;
  logic signed [CW-1:0] pick_ext;
  logic signed [CW-1:0] band;
  logic signed [CW-1:0] floor_ext;
  logic                 pick;
  logic                 hold;

  always_comb begin
    op_a      = {{2{val_a[prot_stage_pkg::VAL_W-1]}}, val_a};
    op_b      = {{2{val_b[prot_stage_pkg::VAL_W-1]}}, val_b};
    pick_ext  = {{2{cfg.pickup[prot_stage_pkg::VAL_W-1]}}, cfg.pickup};
    band      = {2'b00, cfg.hysteresis};
    floor_ext = {{2{cfg.no_compare_floor[prot_stage_pkg::VAL_W-1]}}, cfg.no_compare_floor};
    case (cfg.comparison_selector)
      prot_stage_pkg::DIFFERENCE_MODE: sup = op_a - op_b;
      prot_stage_pkg::ABSOLUTE_DIFFERENCE_MODE: begin
        sup = (op_a < op_b) ? op_b - op_a : op_a - op_b;
      end
      default: sup = op_a;
    endcase
    case (cfg.comparison_selector)
      prot_stage_pkg::UNDER_MODE: begin
        pick = (sup < pick_ext) && (sup >= floor_ext);
        hold = (sup < pick_ext + band) && (sup >= floor_ext);
      end
      default: begin
        pick = sup > pick_ext;
        hold = sup > pick_ext - band;
      end
    endcase
  end

  // ****************************************
  // Start, trip and delay
  // ****************************************
  logic [prot_stage_pkg::DLY_W-1:0] elapsed;
  logic                             next_start;

  assign next_start = cfg.enable && (stat.start ? hold : pick);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat.start <= 1'b0;
      stat.trip  <= 1'b0;
      elapsed    <= '0;
    end else if (force_on && force_wr) begin
      stat.start <= force_start;
      stat.trip  <= force_trip;
    end else if (tick) begin
      stat.start <= next_start;
      if (!next_start) begin
        elapsed    <= '0;
        stat.trip  <= 1'b0;
      end else if (elapsed >= cfg.delay_ticks) begin
        stat.trip  <= 1'b1;
      end else begin
        elapsed    <= elapsed + 1'b1;
      end
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  logic start_q;
  logic trip_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= 1'b0;
      trip_q  <= 1'b0;
      stat.start_event_count <= prot_stage_pkg::CNT_RESET;
      stat.trip_event_count  <= prot_stage_pkg::CNT_RESET;
    end else begin
      start_q <= stat.start;
      trip_q  <= stat.trip;
      if (stat.start && !start_q) begin
        stat.start_event_count <= stat.start_event_count + 1'b1;
      end else if (clear_counts) begin
        stat.start_event_count <= prot_stage_pkg::CNT_RESET;
      end
      if (stat.trip && !trip_q) begin
        stat.trip_event_count <= stat.trip_event_count + 1'b1;
      end else if (clear_counts) begin
        stat.trip_event_count <= prot_stage_pkg::CNT_RESET;
      end
    end
  end

  // ****************************************
  // Fault log, eight latest
  // ****************************************
  prot_stage_pkg::fault_rec_t log_mem [prot_stage_pkg::FAULT_DEPTH];
  logic [2:0]                 wr_ptr;
  logic [7:0]                 pct;
  logic [7:0]                 pct_q;
  logic signed [prot_stage_pkg::VAL_W-1:0] val_q;
  logic [prot_stage_pkg::DLY_W+7-1:0] pct_wide;

  always_comb begin
    pct_wide = (cfg.delay_ticks == '0) ? 23'(prot_stage_pkg::PCT_FULL)
             : 23'((23'(elapsed) * 23'(prot_stage_pkg::PCT_FULL)) / 23'(cfg.delay_ticks));
    pct = (pct_wide > 23'(prot_stage_pkg::PCT_FULL)) ? prot_stage_pkg::PCT_FULL
                                                     : pct_wide[7:0];
  end

  // Release clears elapsed and trip, so the record uses values held a cycle earlier
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pct_q <= 8'h00;
      val_q <= '0;
    end else begin
      pct_q <= pct;
      if (stat.start && !tick) begin
        val_q <= sup[prot_stage_pkg::VAL_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= 3'h0;
      for (int i = 0; i < prot_stage_pkg::FAULT_DEPTH; i++) begin
        log_mem[i] <= '0;
      end
    end else if (!stat.start && start_q) begin
      log_mem[wr_ptr] <= '{stamp: stamp, value: val_q,
                           elapsed_delay_ratio: trip_q ? prot_stage_pkg::PCT_FULL : pct_q,
                           active_settings_bank: bank};
      wr_ptr <= wr_ptr + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      log_out <= '0;
    end else begin
      log_out <= log_mem[wr_ptr - 3'h1 - log_idx];
    end
  end

endmodule : prot_stage_unit

// >>> src/prot_stage_top.sv
// Eight programmable protection stages with selector, banks and force flag
`timescale 1ns/1ns
module prot_stage_top #(
  parameter longint FORCE_CYCLES = prot_stage_pkg::FORCE_CYCLES
) (
  input  wire logic                               ref_clk,
  input  wire logic                               arst_n,
  input  wire logic signed [prot_stage_pkg::VAL_W-1:0] quantities [prot_stage_pkg::NUM_SIGNALS],
  input  prot_stage_pkg::stage_cfg_t              bank_cfg [prot_stage_pkg::NUM_GROUPS]
                                                          [prot_stage_pkg::NUM_STAGES],
  input  wire logic [1:0]                         manual_bank,
  input  wire logic                               bank_by_input,
  input  wire logic [1:0]                         bank_inputs,
  input  wire logic                               force_set,
  input  wire logic                               force_clear,
  input  wire logic                               force_wr,
  input  wire logic [prot_stage_pkg::NUM_STAGES-1:0] force_start,
  input  wire logic [prot_stage_pkg::NUM_STAGES-1:0] force_trip,
  input  wire logic [prot_stage_pkg::NUM_STAGES-1:0] clear_counts,
  input  wire logic [prot_stage_pkg::STAMP_W-1:0] stamp,
  input  wire logic [2:0]                         log_idx,
  output prot_stage_pkg::stage_stat_t             stat [prot_stage_pkg::NUM_STAGES],
  output prot_stage_pkg::fault_rec_t              log_out [prot_stage_pkg::NUM_STAGES],
  output logic                                    force_on,
  output logic [1:0]                              active_settings_bank
);

  // ****************************************
  // Setting bank select
  // ****************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_settings_bank <= 2'h0;
    end else begin
      active_settings_bank <= bank_by_input ? bank_inputs : manual_bank;
    end
  end

  // ****************************************
  // Force flag with timeout
  // ****************************************
  logic [prot_stage_pkg::FORCE_CNT_W-1:0] force_cnt;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      force_on  <= 1'b0;
      force_cnt <= '0;
    end else if (force_set && !force_on) begin
      force_on  <= 1'b1;
      force_cnt <= '0;
    end else if (force_clear) begin
      force_on  <= 1'b0;
    end else if (force_on) begin
      if (force_cnt >= prot_stage_pkg::FORCE_CNT_W'(FORCE_CYCLES - 1)) begin
        force_on <= 1'b0;
      end else begin
        force_cnt <= force_cnt + 1'b1;
      end
    end
  end

  // ****************************************
  // Priority ticks, one divider per rate
  // ****************************************
  logic [prot_stage_pkg::TICK_W-1:0] div [3];
  logic [2:0]                        tick_rate;
  localparam longint DIVS [3] = '{prot_stage_pkg::PRIO_10_CYC,
                                  prot_stage_pkg::PRIO_20_CYC,
                                  prot_stage_pkg::PRIO_100_CYC};

  genvar r;
  generate
    for (r = 0; r < 3; r++) begin : g_div
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          div[r]       <= '0;
          tick_rate[r] <= 1'b0;
        end else if (div[r] == prot_stage_pkg::TICK_W'(DIVS[r] - 1)) begin
          div[r]       <= '0;
          tick_rate[r] <= 1'b1;
        end else begin
          div[r]       <= div[r] + 1'b1;
          tick_rate[r] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // Stages
  // ****************************************
  genvar s;
  generate
    for (s = 0; s < prot_stage_pkg::NUM_STAGES; s++) begin : g_stage
      prot_stage_pkg::stage_cfg_t cfg;
      logic                       tick;
      logic signed [prot_stage_pkg::VAL_W-1:0] sel_a;
      logic signed [prot_stage_pkg::VAL_W-1:0] sel_b;
      assign cfg  = bank_cfg[active_settings_bank][s];
      // Unused priority code and codes past the table read as idle, never unknown
      assign tick = (cfg.prio <= prot_stage_pkg::PRIO_100) && tick_rate[cfg.prio];
      assign sel_a = (cfg.coupling_a < prot_stage_pkg::SEL_W'(prot_stage_pkg::NUM_SIGNALS))
                   ? quantities[cfg.coupling_a] : '0;
      assign sel_b = (cfg.coupling_b < prot_stage_pkg::SEL_W'(prot_stage_pkg::NUM_SIGNALS))
                   ? quantities[cfg.coupling_b] : '0;
      prot_stage_unit u_stage (
        .ref_clk      (ref_clk),
        .arst_n       (arst_n),
        .tick         (tick),
        .cfg          (cfg),
        .val_a        (sel_a),
        .val_b        (sel_b),
        .force_on     (force_on),
        .force_wr     (force_wr),
        .force_start  (force_start[s]),
        .force_trip   (force_trip[s]),
        .clear_counts (clear_counts[s]),
        .bank         (active_settings_bank),
        .stamp        (stamp),
        .log_idx      (log_idx),
        .stat         (stat[s]),
        .log_out      (log_out[s])
      );
    end
  endgenerate

endmodule : prot_stage_top

// >>> verif/prot_stage_checker.sv
// Port assertions for the eight-stage protection block
`timescale 1ns/1ns
module prot_stage_checker #(
  parameter longint FORCE_CYCLES = 1000
) (
  input wire logic                                   ref_clk,
  input wire logic                                   arst_n,
  input wire logic [1:0]                             manual_bank,
  input wire logic                                   bank_by_input,
  input wire logic [1:0]                             bank_inputs,
  input wire logic                                   force_set,
  input wire logic                                   force_clear,
  input wire logic                                   force_wr,
  input wire logic [prot_stage_pkg::NUM_STAGES-1:0]  force_start,
  input wire logic [prot_stage_pkg::NUM_STAGES-1:0]  clear_counts,
  input prot_stage_pkg::stage_stat_t                 stat [prot_stage_pkg::NUM_STAGES],
  input wire logic                                   force_on,
  input wire logic [1:0]                             active_settings_bank
);
  // ****************************************
  // Helper: cycles the force flag has stood
  // ****************************************
  // A set while the flag is on is ignored by the block, so the count needs no restart rule
  longint on_cnt;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      on_cnt <= 0;
    end else begin
      on_cnt <= force_on ? on_cnt + 1 : 0;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_forced_write;
    force_on && force_wr;
  endsequence
  sequence s_clear_only;
    force_clear && !force_set;
  endsequence

  // ****************************************
  // Properties
  // ****************************************
  a_force_set_on: assert property ((force_set && !force_on) |=> force_on)
    else $error("force flag not set");
  a_force_clear_off: assert property (s_clear_only |=> !force_on)
    else $error("force flag not cleared");
  a_force_time_limit: assert property (on_cnt <= FORCE_CYCLES + 2)
    else $error("force flag outlived its timeout");
  a_force_holds_on: assert property ((force_on && !force_clear && on_cnt < FORCE_CYCLES - 2)
    |=> force_on)
    else $error("force flag dropped early");
  a_bank_manual: assert property (!bank_by_input |=> active_settings_bank == $past(manual_bank))
    else $error("manual bank not applied");
  a_bank_by_inputs: assert property (bank_by_input |=> active_settings_bank == $past(bank_inputs))
    else $error("input bank not applied");
  a_forced_start_write: assert property (s_forced_write |=> stat[0].start == $past(force_start[0]))
    else $error("forced start not written");
  a_count_clear: assert property ((clear_counts[0] && !$rose(stat[0].start)) |=>
    stat[0].start_event_count == 16'h0000)
    else $error("start count not cleared");
  a_trip_count_step: assert property ($changed(stat[0].trip_event_count) |->
    (stat[0].trip_event_count == $past(stat[0].trip_event_count) + 16'h0001
     || stat[0].trip_event_count == 16'h0000))
    else $error("trip count jumped");
endmodule : prot_stage_checker

bind prot_stage_top prot_stage_checker #(.FORCE_CYCLES(FORCE_CYCLES)) chk_u (
  .ref_clk(ref_clk), .arst_n(arst_n), .manual_bank(manual_bank),
  .bank_by_input(bank_by_input), .bank_inputs(bank_inputs), .force_set(force_set),
  .force_clear(force_clear), .force_wr(force_wr), .force_start(force_start),
  .clear_counts(clear_counts), .stat(stat), .force_on(force_on),
  .active_settings_bank(active_settings_bank)
);

// >>> verif/quantity_source.sv
// Measurement side model: a fresh value on each of the 48 signal selector codes each cycle
`timescale 1ns/1ns
module quantity_source (
  input wire logic                                    ref_clk,
  input wire logic                                    arst_n,
  output logic signed [prot_stage_pkg::VAL_W-1:0]     quantities [prot_stage_pkg::NUM_SIGNALS]
);
  logic [23:0] state;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= 24'h00ACE1;
      for (int i = 0; i < prot_stage_pkg::NUM_SIGNALS; i++) quantities[i] <= '0;
    end else begin
      state <= {state[22:0], state[23] ^ state[22] ^ state[21] ^ state[16]};
      // Values keep moving so a stale sample cannot pass for a live one
      for (int i = 0; i < prot_stage_pkg::NUM_SIGNALS; i++) quantities[i] <= state ^ 24'(i * 7919);
    end
  end
endmodule : quantity_source

// >>> verif/programmable_protection_stage_tb.sv
// Self-checking bench for the eight-stage protection block
`timescale 1ns/1ns
module programmable_protection_stage_tb;
  localparam longint FC = 1000;
  logic                       ref_clk, arst_n, bank_by_input, force_set, force_clear, force_wr;
  logic signed [23:0]         quantities [prot_stage_pkg::NUM_SIGNALS];
  prot_stage_pkg::stage_cfg_t bank_cfg [prot_stage_pkg::NUM_GROUPS][prot_stage_pkg::NUM_STAGES];
  logic [1:0]                 manual_bank, bank_inputs, active_settings_bank;
  logic [7:0]                 force_start, force_trip, clear_counts, exp_start, exp_trip;
  logic [47:0]                stamp;
  logic [2:0]                 log_idx;
  prot_stage_pkg::stage_stat_t stat [prot_stage_pkg::NUM_STAGES];
  prot_stage_pkg::fault_rec_t  log_out [prot_stage_pkg::NUM_STAGES];
  logic                       force_on, exp_force;
  logic [1:0]                 exp_bank;
  logic [15:0]                lfsr_state;
  int                         miscompares, check_count, n;
  int                         exp_scnt [8], exp_tcnt [8];
  logic [47:0]                t_on;
  logic [111:0]               cfg_bits;

  quantity_source src_u (.ref_clk(ref_clk), .arst_n(arst_n), .quantities(quantities));
  prot_stage_top #(.FORCE_CYCLES(FC)) dut_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .quantities(quantities), .bank_cfg(bank_cfg),
    .manual_bank(manual_bank), .bank_by_input(bank_by_input), .bank_inputs(bank_inputs),
    .force_set(force_set), .force_clear(force_clear), .force_wr(force_wr),
    .force_start(force_start), .force_trip(force_trip), .clear_counts(clear_counts),
    .stamp(stamp), .log_idx(log_idx), .stat(stat), .log_out(log_out), .force_on(force_on),
    .active_settings_bank(active_settings_bank));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] rnd();
    lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
    return lfsr_state;
  endfunction : rnd

  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic check_all();
    check("force_on", exp_force, force_on);
    check("bank", exp_bank, active_settings_bank);
    for (int i = 0; i < 8; i++) begin
      check("start", exp_start[i], stat[i].start);
      check("trip", exp_trip[i], stat[i].trip);
    end
  endtask : check_all

  // One-cycle pulse on the force controls, then the model follows
  task automatic pulse(logic set, logic clr, logic wr, logic [7:0] st, logic [7:0] tr);
    @(posedge ref_clk);
    force_set <= set; force_clear <= clr; force_wr <= wr; force_start <= st; force_trip <= tr;
    @(posedge ref_clk);
    force_set <= 1'b0; force_clear <= 1'b0; force_wr <= 1'b0;
    #1;
    if (wr && exp_force) begin
      for (int i = 0; i < 8; i++) begin
        if (st[i] && !exp_start[i]) exp_scnt[i]++;
        if (tr[i] && !exp_trip[i]) exp_tcnt[i]++;
      end
      exp_start = st;
      exp_trip = tr;
    end
    // Set only takes while the flag is off; once on, clear wins
    exp_force = (set && !exp_force) ? 1'b1 : (clr ? 1'b0 : exp_force);
    check_all();
  endtask : pulse

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) stamp <= stamp + 48'h1;
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    lfsr_state = 16'hAD50; miscompares = 0; check_count = 0; arst_n = 1'b0; stamp = '0;
    manual_bank = 2'h0; bank_by_input = 1'b0; bank_inputs = 2'h0; log_idx = 3'h0;
    force_set = 1'b0; force_clear = 1'b0; force_wr = 1'b0; force_start = '0; force_trip = '0;
    clear_counts = '0; exp_force = 1'b0; exp_bank = 2'h0; exp_start = '0; exp_trip = '0;
    for (int g = 0; g < 4; g++) for (int s = 0; s < 8; s++) begin
      cfg_bits = {7{rnd()}};
      bank_cfg[g][s] = cfg_bits[$bits(prot_stage_pkg::stage_cfg_t)-1:0];
      bank_cfg[g][s].prio = prot_stage_pkg::PRIO_10;
    end
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    check_all();
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      manual_bank <= 2'(rnd());
      bank_inputs <= 2'(rnd());
      bank_by_input <= i[0];
      log_idx <= 3'(rnd());
      @(posedge ref_clk);
      #1;
      exp_bank = bank_by_input ? bank_inputs : manual_bank;
      check_all();
    end
    pulse(1'b0, 1'b0, 1'b1, 8'hFF, 8'hFF);
    pulse(1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
    t_on = stamp;
    for (int k = 0; k < 4; k++) pulse(1'b0, 1'b0, 1'b1, 8'(rnd()), 8'(rnd()));
    pulse(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++) check("start_cnt", 16'(exp_scnt[i]), stat[i].start_event_count);
    for (int i = 0; i < 8; i++) check("trip_cnt", 16'(exp_tcnt[i]), stat[i].trip_event_count);
    @(posedge ref_clk);
    clear_counts <= 8'hFF;
    @(posedge ref_clk);
    clear_counts <= 8'h00;
    #1;
    for (int i = 0; i < 8; i++) check("start_cnt", 16'h0000, stat[i].start_event_count);
    for (int i = 0; i < 8; i++) check("trip_cnt", 16'h0000, stat[i].trip_event_count);
    for (int i = 0; i < 8; i++) begin
      exp_scnt[i] = 0;
      exp_tcnt[i] = 0;
    end
    n = 0;
    while (force_on === 1'b1 && n < FC + 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    exp_force = 1'b0;
    check("force_time", 16'(FC), 16'(stamp - t_on));
    pulse(1'b0, 1'b0, 1'b1, 8'hA5, 8'h5A);
    pulse(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
    pulse(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
    give_verdict();
  end
endmodule : programmable_protection_stage_tb
